// *** design/ssm_consts.svh ***
// register offsets, field positions, reset values and character sizes of the serial block
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

`define SSM_ADDR_W      3
`define SSM_OFF_TXSC    3'h0
`define SSM_OFF_RXSC    3'h1
`define SSM_OFF_BAUD    3'h2
`define SSM_OFF_DIVL    3'h3
`define SSM_OFF_DIVH    3'h4
`define SSM_OFF_DATA    3'h5
`define SSM_OFF_FLAG    3'h6

`define SSM_TX_MASTER   7
`define SSM_TX_NINE     6
`define SSM_TX_EN       5
`define SSM_TX_SYNC     4
`define SSM_TX_BRK      3
`define SSM_TX_HSPD     2
`define SSM_TX_IDLE     1
`define SSM_TX_D9       0

`define SSM_RX_PEN      7
`define SSM_RX_NINE     6
`define SSM_RX_SGL      5
`define SSM_RX_CONT     4
`define SSM_RX_ADDR     3
`define SSM_RX_OVR      1
`define SSM_RX_D9       0

`define SSM_BD_RXIDLE   6
`define SSM_BD_POL      4
`define SSM_BD_WIDE     3

`define SSM_FL_TXE      0
`define SSM_FL_RXF      1

`define SSM_RST_BYTE    8'h00
`define SSM_CHAR8       4'h8
`define SSM_CHAR9       4'h9

`endif

// *** design/ssm_pkg.sv ***
// types shared by the serial block modules
package ssm_pkg;
	typedef enum logic [1:0] {SSM_IDLE, SSM_TX, SSM_RX} ssm_state_t;
	typedef logic [8:0] ssm_char_t;
endpackage

// *** design/ssm_rxq_if.sv ***
// receive queue signals between the engine and the character fifo
`timescale 1ns/1ps
`default_nettype none
interface ssm_rxq_if #(parameter int WIDTH = 9);
	logic             push;
	logic [WIDTH-1:0] wdata;
	logic             pop;
	logic             flush;
	logic [WIDTH-1:0] head;
	logic             full;
	logic             empty;
	modport src  (output push, wdata, pop, flush, input head, full, empty);
	modport sink (input push, wdata, pop, flush, output head, full, empty);
endinterface
`default_nettype wire

// *** design/ssm_sync.sv ***
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module ssm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// *** design/ssm_rx_fifo.sv ***
// small receive character fifo, oldest entry shown at the head
`timescale 1ns/1ps
`default_nettype none
module ssm_rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	ssm_rxq_if.sink   q
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r;
	logic [PW-1:0]    rd_ptr_r;
	logic [PW:0]      count_r;
	logic             do_push;
	logic             do_pop;

	assign q.full  = (count_r == (PW+1)'(DEPTH));
	assign q.empty = (count_r == '0);
	assign q.head  = mem_r[rd_ptr_r];
	assign do_push = q.push && !q.full;
	assign do_pop  = q.pop && !q.empty;

	// storage, written only when there is room
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_r[wr_ptr_r] <= q.wdata;
		end
	end

	// pointers and fill level
	always_ff @(posedge clk) begin
		if (sys_rst || q.flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (do_push) wr_ptr_r <= wr_ptr_r + 1'b1;
			if (do_pop) rd_ptr_r <= rd_ptr_r + 1'b1;
			count_r <= count_r + (PW+1)'(do_push) - (PW+1)'(do_pop);
		end
	end
endmodule
`default_nettype wire

// *** design/ssm_core.sv ***
// synchronous half-duplex serial engine with register port, master or slave clocking
//
// Summary of operation
// - sync bit selects mode, master bit drives clock, enable bit activates
// - both receive enables clear means transmit, either set means receive
// - characters carry data bits only, no start or stop bits
// - master drives and enables the clock pin in transmit and receive
// - master emits one clock per data bit and no extra clocks
// - transmit data changes on leading edge, valid at trailing edge
// - polarity set idles clock high; clear idles clock low
// - master transmit enables both data and clock pin drivers
// - data write loads holding register, moves to shifter when shifter free
// - master receive turns data pin driver off
// - single receive clocks one character then clears its enable
// - continuous receive runs until cleared; clearing aborts the partial character
// - both enables set: single clears after first character, continuous continues
// - receive samples data pin on each trailing clock edge
// - complete characters enter two-entry fifo; receive flag while unread
// - slave takes clock from pin, clock driver off, one bit per clock
// - third character with fifo full sets overrun, keeps entries, blocks receive
// - overrun cleared by data read in single mode, else by enable clears
// - nine-bit transmit sends the ninth bit loaded beforehand
// - nine-bit receive shifts nine bits; ninth bit readable in status
// - transmit empty flag shows holding register can accept data
//
// The address map and the plain strobed port are this design's own decisions.
`include "ssm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ssm_core
	import ssm_pkg::*;
#(
	parameter int FIFO_DEPTH = 2
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	input  wire logic [`SSM_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	input  wire logic                   clock_pin_i,
	output logic                        clock_pin_o,
	output logic                        clock_pin_oe,
	input  wire logic                   data_pin_i,
	output logic                        data_pin_o,
	output logic                        data_pin_oe
);
	initial begin
		if (FIFO_DEPTH != 2) $error("receive fifo depth must be two");
	end

	// software controls
	logic        clock_master_select_r;
	logic        nine_bit_transmit_r;
	logic        transmit_enable_r;
	logic        sync_select_r;
	logic        break_select_r;
	logic        high_speed_select_r;
	logic        transmit_ninth_bit_r;
	logic        port_enable_r;
	logic        nine_bit_receive_r;
	logic        single_receive_enable_r;
	logic        continuous_receive_enable_r;
	logic        address_detect_r;
	logic        clock_polarity_r;
	logic        wide_divisor_select_r;
	logic [7:0]  divisor_low_byte_r;
	logic [7:0]  divisor_high_byte_r;
	// transmit path
	ssm_char_t   transmit_holding_register_r;
	logic        holding_full_r;
	// engine
	ssm_state_t  state_r;
	ssm_char_t   shifter_r;
	logic [3:0]  bits_left_r;
	logic [15:0] baud_cnt_r;
	logic        ck_act_r;
	logic        ck_prev_r;
	logic        data_out_r;
	logic        overrun_flag_r;
	logic        overrun_cont_r;
	logic        wr_tx_data;
	logic        rd_rx_data;
	logic        unit_on;
	logic        rx_mode;
	logic        half_tick;
	logic        lead_edge;
	logic        trail_edge;
	logic        rx_done;
	logic        tx_start;
	logic        ck_s;
	logic        dt_s;
	logic [15:0] divisor;
	ssm_char_t   rx_word;

	ssm_rxq_if #(.WIDTH(9)) rxq ();

	ssm_rx_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk     (clk),
		.sys_rst (sys_rst),
		.q       (rxq.sink)
	);

	ssm_sync #(.WIDTH(2)) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({clock_pin_i, data_pin_i}),
		.q       ({ck_s, dt_s})
	);

	// register strobes with side effects
	assign wr_tx_data = reg_wr && (reg_addr == `SSM_OFF_DATA);
	assign rd_rx_data = reg_rd && (reg_addr == `SSM_OFF_DATA) && !rxq.empty;
	assign unit_on    = port_enable_r && sync_select_r;
	assign rx_mode    = single_receive_enable_r || continuous_receive_enable_r;
	assign divisor    = wide_divisor_select_r ? {divisor_high_byte_r, divisor_low_byte_r}
	                                          : {8'h00, divisor_low_byte_r};

	// master half-bit tick, counted only while a character is moving
	always_ff @(posedge clk) begin
		if (sys_rst || state_r == SSM_IDLE || half_tick) begin
			baud_cnt_r <= 16'h0000;
		end else begin
			baud_cnt_r <= baud_cnt_r + 16'h0001;
		end
	end
	assign half_tick = (state_r != SSM_IDLE) && (baud_cnt_r == divisor);

	// slave clock edge history
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ck_prev_r <= 1'b0;
		end else begin
			ck_prev_r <= ck_s;
		end
	end

	// slave edges come from the pin, master edges from the tick
	always_comb begin
		if (clock_master_select_r) begin
			lead_edge  = half_tick && !ck_act_r;
			trail_edge = half_tick && ck_act_r;
		end else begin
			lead_edge  = (state_r != SSM_IDLE) && (ck_prev_r == clock_polarity_r)
			             && (ck_s != clock_polarity_r);
			trail_edge = (state_r != SSM_IDLE) && (ck_prev_r != clock_polarity_r)
			             && (ck_s == clock_polarity_r);
		end
	end

	// assemble the finished character, lsb first
	assign rx_word  = nine_bit_receive_r ? {dt_s, shifter_r[8:1]}
	                                     : {1'b0, dt_s, shifter_r[8:2]};
	assign rx_done  = (state_r == SSM_RX) && trail_edge && (bits_left_r == 4'h1);
	// shifter free and holding register loaded
	assign tx_start = (state_r == SSM_IDLE) && unit_on && !rx_mode && transmit_enable_r
	                  && holding_full_r;

	// completed characters go to the fifo
	assign rxq.push  = rx_done && !rxq.full && !overrun_flag_r;
	assign rxq.wdata = rx_word;
	assign rxq.pop   = rd_rx_data;
	assign rxq.flush = !port_enable_r;

	// character engine
	always_ff @(posedge clk) begin
		if (sys_rst || !unit_on) begin
			state_r     <= SSM_IDLE;
			shifter_r   <= 9'h000;
			bits_left_r <= 4'h0;
			ck_act_r    <= 1'b0;
			data_out_r  <= 1'b0;
		end else begin
			case (state_r)
				SSM_IDLE: begin
					ck_act_r <= 1'b0;
					if (tx_start) begin
						// nine or eight bits per character
						shifter_r   <= transmit_holding_register_r;
						bits_left_r <= nine_bit_transmit_r ? `SSM_CHAR9 : `SSM_CHAR8;
						state_r     <= SSM_TX;
					end else if (rx_mode && !overrun_flag_r) begin
						bits_left_r <= nine_bit_receive_r ? `SSM_CHAR9 : `SSM_CHAR8;
						state_r     <= SSM_RX;
					end
				end
				SSM_TX: begin
					if (rx_mode || !transmit_enable_r) begin
						state_r <= SSM_IDLE;
					end else if (lead_edge) begin
						// new bit on the leading edge, held to the next
						data_out_r <= shifter_r[0];
						shifter_r  <= {1'b0, shifter_r[8:1]};
						ck_act_r   <= 1'b1;
					end else if (trail_edge) begin
						// last data bit ends the character, no extra clock
						ck_act_r    <= 1'b0;
						bits_left_r <= bits_left_r - 4'h1;
						if (bits_left_r == 4'h1) state_r <= SSM_IDLE;
					end
				end
				SSM_RX: begin
					if (!rx_mode) begin
						state_r  <= SSM_IDLE;
						ck_act_r <= 1'b0;
					end else if (lead_edge) begin
						ck_act_r <= 1'b1;
					end else if (trail_edge) begin
						shifter_r   <= {dt_s, shifter_r[8:1]};
						ck_act_r    <= 1'b0;
						bits_left_r <= bits_left_r - 4'h1;
						if (bits_left_r == 4'h1) state_r <= SSM_IDLE;
					end
				end
				default: state_r <= SSM_IDLE;
			endcase
		end
	end

	// holding register, loaded on every data write even when full, emptied at transmit start
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			transmit_holding_register_r <= 9'h000;
			holding_full_r              <= 1'b0;
		end else if (wr_tx_data) begin
			transmit_holding_register_r <= {transmit_ninth_bit_r, reg_wdata};
			holding_full_r              <= 1'b1;
		end else if (tx_start) begin
			holding_full_r <= 1'b0;
		end
	end

	// overrun, set wins over every clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			overrun_flag_r <= 1'b0;
			overrun_cont_r <= 1'b0;
		end else if (rx_done && rxq.full && !overrun_flag_r) begin
			overrun_flag_r <= 1'b1;
			overrun_cont_r <= continuous_receive_enable_r;
		end else if (!port_enable_r || !continuous_receive_enable_r && overrun_cont_r) begin
			// enable clears end a continuous overrun
			overrun_flag_r <= 1'b0;
		end else if (rd_rx_data && !overrun_cont_r) begin
			// data read ends a single-receive overrun
			overrun_flag_r <= 1'b0;
		end
	end

	// control registers, written by software
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{clock_master_select_r, nine_bit_transmit_r, transmit_enable_r, sync_select_r,
			 break_select_r, high_speed_select_r, transmit_ninth_bit_r} <= 7'h00;
			{port_enable_r, nine_bit_receive_r, single_receive_enable_r,
			 continuous_receive_enable_r, address_detect_r} <= 5'h00;
			clock_polarity_r      <= 1'b0;
			wide_divisor_select_r <= 1'b0;
			divisor_low_byte_r    <= `SSM_RST_BYTE;
			divisor_high_byte_r   <= `SSM_RST_BYTE;
		end else begin
			// single receive clears itself after one character
			if (rx_done && single_receive_enable_r) single_receive_enable_r <= 1'b0;
			if (reg_wr) begin
				case (reg_addr)
					`SSM_OFF_TXSC: begin
						clock_master_select_r <= reg_wdata[`SSM_TX_MASTER];
						nine_bit_transmit_r   <= reg_wdata[`SSM_TX_NINE];
						transmit_enable_r     <= reg_wdata[`SSM_TX_EN];
						sync_select_r         <= reg_wdata[`SSM_TX_SYNC];
						break_select_r        <= reg_wdata[`SSM_TX_BRK];
						high_speed_select_r   <= reg_wdata[`SSM_TX_HSPD];
						transmit_ninth_bit_r  <= reg_wdata[`SSM_TX_D9];
					end
					`SSM_OFF_RXSC: begin
						port_enable_r               <= reg_wdata[`SSM_RX_PEN];
						nine_bit_receive_r          <= reg_wdata[`SSM_RX_NINE];
						single_receive_enable_r     <= reg_wdata[`SSM_RX_SGL];
						continuous_receive_enable_r <= reg_wdata[`SSM_RX_CONT];
						address_detect_r            <= reg_wdata[`SSM_RX_ADDR];
					end
					`SSM_OFF_BAUD: begin
						clock_polarity_r      <= reg_wdata[`SSM_BD_POL];
						wide_divisor_select_r <= reg_wdata[`SSM_BD_WIDE];
					end
					`SSM_OFF_DIVL: divisor_low_byte_r <= reg_wdata;
					`SSM_OFF_DIVH: divisor_high_byte_r <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (sys_rst || !reg_rd) begin
			reg_rdata <= 8'h00;
		end else begin
			case (reg_addr)
				`SSM_OFF_TXSC: reg_rdata <= {clock_master_select_r, nine_bit_transmit_r,
				                             transmit_enable_r, sync_select_r, break_select_r,
				                             high_speed_select_r, state_r != SSM_TX,
				                             transmit_ninth_bit_r};
				// ninth bit of the oldest entry
				`SSM_OFF_RXSC: reg_rdata <= {port_enable_r, nine_bit_receive_r,
				                             single_receive_enable_r,
				                             continuous_receive_enable_r, address_detect_r,
				                             1'b0, overrun_flag_r, rxq.head[8]};
				`SSM_OFF_BAUD: reg_rdata <= {1'b0, state_r != SSM_RX, 1'b0, clock_polarity_r,
				                             wide_divisor_select_r, 3'h0};
				`SSM_OFF_DIVL: reg_rdata <= divisor_low_byte_r;
				`SSM_OFF_DIVH: reg_rdata <= divisor_high_byte_r;
				// low byte of the oldest entry
				`SSM_OFF_DATA: reg_rdata <= rxq.head[7:0];
				`SSM_OFF_FLAG: reg_rdata <= {6'h00, !rxq.empty, !holding_full_r};
				default:       reg_rdata <= 8'h00;
			endcase
		end
	end

	// clock idles at the polarity level, driven only as master
	assign clock_pin_o  = ck_act_r ^ clock_polarity_r;
	assign clock_pin_oe = unit_on && clock_master_select_r;
	assign data_pin_o   = data_out_r;
	assign data_pin_oe  = unit_on && !rx_mode && transmit_enable_r;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic [3:0] lead_cnt_r;
	always_ff @(posedge clk) begin
		if (sys_rst || state_r == SSM_IDLE) begin
			lead_cnt_r <= 4'h0;
		end else if (lead_edge) begin
			lead_cnt_r <= lead_cnt_r + 4'h1;
		end
	end

	sequence s_load;
		state_r == SSM_IDLE && tx_start;
	endsequence
	sequence s_shift;
		state_r == SSM_TX;
	endsequence

	a_clk_idle_level: assert property (ck_act_r == 1'b0 |-> clock_pin_o == clock_polarity_r)
		else $error("clock not at idle level");
	a_clk_drive_mode: assert property (state_r != SSM_IDLE && clock_master_select_r
		|-> clock_pin_oe) else $error("master clock not driven");
	a_slave_clk_off: assert property (!clock_master_select_r |-> !clock_pin_oe)
		else $error("slave drives clock");
	a_rx_data_off: assert property (state_r == SSM_RX |-> !data_pin_oe)
		else $error("data driven during receive");
	a_tx_load_start: assert property (s_load |=> s_shift ##1 s_shift)
		else $error("loaded character not shifting");
	a_clk_per_bit: assert property (state_r != SSM_IDLE |-> lead_cnt_r <= (state_r == SSM_TX
		? (nine_bit_transmit_r ? `SSM_CHAR9 : `SSM_CHAR8)
		: (nine_bit_receive_r ? `SSM_CHAR9 : `SSM_CHAR8))) else $error("extra clock cycles");
	a_single_clear: assert property (rx_done && !continuous_receive_enable_r && !reg_wr
		|=> !single_receive_enable_r && state_r == SSM_IDLE) else $error("single receive kept");
	a_abort_stops: assert property (state_r == SSM_RX && $fell(continuous_receive_enable_r)
		&& !single_receive_enable_r |=> state_r == SSM_IDLE ##1 !ck_act_r)
		else $error("abort did not stop clock");
	a_ovr_keeps: assert property ($rose(overrun_flag_r) |-> rxq.full && $stable(rxq.head))
		else $error("overrun without full fifo");
	a_ovr_blocks: assert property (overrun_flag_r && state_r == SSM_IDLE |=> state_r != SSM_RX)
		else $error("receive during overrun");
endmodule
`default_nettype wire

// *** dv/ssm_far_end.sv ***
// far-side serial device model: clock source as master, shifter as slave
`timescale 1ns/1ps
`default_nettype none
module ssm_far_end (
	input  wire logic        ck_line,
	input  wire logic        dt_line,
	input  wire logic        pol,
	input  wire logic [31:0] tx_word,
	output logic             ck_o,
	output logic             dt_o,
	output logic [31:0]      rx_word,
	output int               n_trail
);
	logic ph;
	int   idx;
	// clock rests at the polarity level outside frames
	assign ck_o = pol ^ ph;
	// start from a quiet line
	initial begin
		ph = 1'h0;
		dt_o = 1'h0;
		rx_word = 32'h00000000;
		n_trail = 0;
		idx = 0;
	end
	// restart bit counters between frames
	task clear();
		idx = 0;
		n_trail = 0;
	endtask
	task run_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			#80 ph = 1'h1;
			#80 ph = 1'h0;
		end
	endtask
	// change on leading, sample on trailing
	always @(ck_line) begin
		if (ck_line === ~pol) begin
			dt_o = tx_word[idx[4:0]];
			idx++;
		end else if (ck_line === pol) begin
			rx_word = {dt_line, rx_word[31:1]};
			n_trail++;
		end
	end
endmodule
`default_nettype wire

// *** dv/sync_serial_master_slave_tb_top.sv ***
// self-checking bench for the synchronous serial block
`include "ssm_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sync_serial_master_slave_tb_top;
	localparam logic [7:0] PEN  = 8'h01 << `SSM_RX_PEN;
	localparam logic [7:0] SGL  = 8'h01 << `SSM_RX_SGL;
	localparam logic [7:0] CONT = 8'h01 << `SSM_RX_CONT;
	localparam logic [7:0] OVR  = 8'h01 << `SSM_RX_OVR;
	localparam logic [7:0] MSTR = 8'h01 << `SSM_TX_MASTER;
	localparam logic [7:0] SYNC = 8'h01 << `SSM_TX_SYNC;
	localparam logic [7:0] TXON = 8'h01 << `SSM_TX_EN;
	logic        clk, sys_rst, reg_wr, reg_rd, pol, talk, flt;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, rv;
	logic        ck_o, ck_oe, dt_o, dt_oe, far_ck, far_dt, ck_line, dt_line;
	logic [31:0] tx_word, rx_word, lfsr_r;
	int          n_trail, n_mismatch, samples_checked;
	// clock and a pattern for a released data line
	always #10 clk = ~clk;
	always @(posedge clk) flt <= ~flt;
	// pin levels from every driver, a data line clash shows as unknown
	assign ck_line = ck_oe ? ck_o : far_ck;
	assign dt_line = (dt_oe & talk) ? 1'bx : dt_oe ? dt_o : talk ? far_dt : flt;
	ssm_core u_dut (
		.clk          (clk),
		.sys_rst      (sys_rst),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.clock_pin_i  (ck_line),
		.clock_pin_o  (ck_o),
		.clock_pin_oe (ck_oe),
		.data_pin_i   (dt_line),
		.data_pin_o   (dt_o),
		.data_pin_oe  (dt_oe)
	);
	ssm_far_end u_far (
		.ck_line (ck_line),
		.dt_line (dt_line),
		.pol     (pol),
		.tx_word (tx_word),
		.ck_o    (far_ck),
		.dt_o    (far_dt),
		.rx_word (rx_word),
		.n_trail (n_trail)
	);
	// random source and expected bit stream
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function logic [31:0] tx_exp(input logic [7:0] b1, input logic [7:0] b2,
		input logic d9, input logic nine);
		return nine ? {d9, b2, d9, b1, 14'h0000} : {b2, b1, 16'h0000};
	endfunction
	// comparison and verdict
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// register port cycles
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	// wait for n trailing edges, then let any extra clocks show
	task wait_trail(input int n);
		for (int i = 0; i < 5000 && n_trail < n; i++)
			@(posedge clk);
		repeat (40) @(posedge clk);
	endtask
	// reset values, read-back and the unmapped index
	task test_regs();
		for (int a = 1; a < 5; a++) begin
			if (a != 2) begin
				rd(3'(a), rv);
				chk("reset_value", rv, 8'h00);
			end
		end
		chk("reset_oe", {ck_oe, dt_oe}, 2'h0);
		wr(`SSM_OFF_DIVH, lfsr_r[7:0]);
		wr(3'h7, 8'hFF);
		rd(`SSM_OFF_DIVH, rv);
		chk("divisor_readback", rv, lfsr_r[7:0]);
		rd(3'h7, rv);
		chk("unmapped", rv, 8'h00);
		wr(`SSM_OFF_DIVH, 8'h00);
		lfsr_r = lfsr(lfsr_r);
		$display("test regs done");
	endtask
	// master transmit, two characters back to back
	task test_tx(input logic p, input logic nine);
		logic [31:0] mask;
		mask = nine ? 32'hFFFFC000 : 32'hFFFF0000;
		pol <= p;
		wr(`SSM_OFF_DIVL, 8'h03);
		wr(`SSM_OFF_BAUD, 8'(p) << `SSM_BD_POL);
		wr(`SSM_OFF_RXSC, PEN);
		wr(`SSM_OFF_TXSC, MSTR | SYNC | TXON | (8'(nine) << `SSM_TX_NINE) | 8'(lfsr_r[16]));
		u_far.clear();
		wr(`SSM_OFF_DATA, lfsr_r[7:0]);
		wr(`SSM_OFF_DATA, lfsr_r[15:8]);
		rd(`SSM_OFF_FLAG, rv);
		chk("tx_empty_busy", rv[`SSM_FL_TXE], 1'h0);
		chk("tx_oe", {ck_oe, dt_oe}, 2'h3);
		wait_trail(nine ? 18 : 16);
		chk("tx_clocks", n_trail, nine ? 18 : 16);
		chk("tx_bits", rx_word & mask, tx_exp(lfsr_r[7:0], lfsr_r[15:8], lfsr_r[16], nine));
		chk("ck_idle", ck_line, p);
		rd(`SSM_OFF_FLAG, rv);
		chk("tx_empty_idle", rv[`SSM_FL_TXE], 1'h1);
		wr(`SSM_OFF_RXSC, 8'h00);
		lfsr_r = lfsr(lfsr_r);
		$display("test tx done");
	endtask
	// common receive setup, master or slave as txc selects
	task rx_setup(input logic [7:0] txc, input logic [7:0] cfg);
		tx_word <= lfsr_r;
		lfsr_r = lfsr(lfsr_r);
		pol <= 1'h0;
		wr(`SSM_OFF_DIVL, 8'h03);
		wr(`SSM_OFF_BAUD, 8'h00);
		wr(`SSM_OFF_TXSC, txc);
		wr(`SSM_OFF_RXSC, cfg);
		talk <= 1'h1;
		u_far.clear();
	endtask
	// master single receive of one character
	task test_rx1(input logic nine);
		logic [7:0] cfg;
		cfg = PEN | (8'(nine) << `SSM_RX_NINE);
		rx_setup(MSTR | SYNC, cfg);
		wr(`SSM_OFF_RXSC, cfg | SGL);
		chk("rx_oe", {ck_oe, dt_oe}, 2'h2);
		wait_trail(nine ? 9 : 8);
		chk("rx1_clocks", n_trail, nine ? 9 : 8);
		rd(`SSM_OFF_RXSC, rv);
		chk("rx1_status", rv, cfg | 8'(nine & tx_word[8]));
		rd(`SSM_OFF_FLAG, rv);
		chk("rx1_flag", rv[`SSM_FL_RXF], 1'h1);
		rd(`SSM_OFF_DATA, rv);
		chk("rx1_data", rv, tx_word[7:0]);
		rd(`SSM_OFF_FLAG, rv);
		chk("rx1_empty", rv[`SSM_FL_RXF], 1'h0);
		wr(`SSM_OFF_RXSC, 8'h00);
		talk <= 1'h0;
		$display("test rx single done");
	endtask
	// both enables, then continuous receive into overrun and abort
	task test_ovr();
		int cnt;
		rx_setup(MSTR | SYNC, PEN);
		wr(`SSM_OFF_RXSC, PEN | SGL | CONT);
		wait_trail(8);
		rd(`SSM_OFF_RXSC, rv);
		chk("both_enables", rv, PEN | CONT);
		wait_trail(24);
		rd(`SSM_OFF_RXSC, rv);
		chk("ovr_set", rv, PEN | CONT | OVR);
		rd(`SSM_OFF_DATA, rv);
		chk("ovr_first", rv, tx_word[7:0]);
		rd(`SSM_OFF_DATA, rv);
		chk("ovr_second", rv, tx_word[15:8]);
		rd(`SSM_OFF_FLAG, rv);
		chk("ovr_blocked", rv[`SSM_FL_RXF], 1'h0);
		wr(`SSM_OFF_RXSC, PEN);
		rd(`SSM_OFF_RXSC, rv);
		chk("ovr_clear", rv, PEN);
		// restart, then abort three bits into a character
		cnt = n_trail + 3;
		wr(`SSM_OFF_RXSC, PEN | CONT);
		for (int i = 0; i < 500 && n_trail < cnt; i++)
			@(posedge clk);
		wr(`SSM_OFF_RXSC, PEN);
		repeat (3) @(posedge clk);
		cnt = n_trail;
		repeat (40) @(posedge clk);
		chk("cont_stop", n_trail, cnt);
		rd(`SSM_OFF_FLAG, rv);
		chk("partial_drop", rv[`SSM_FL_RXF], 1'h0);
		wr(`SSM_OFF_RXSC, 8'h00);
		talk <= 1'h0;
		$display("test overrun done");
	endtask
	// slave receive on a clock from the far side
	task test_slave();
		rx_setup(SYNC, PEN | CONT);
		chk("slave_ck_oe", ck_oe, 1'h0);
		#7;
		u_far.run_clocks(8);
		repeat (20) @(posedge clk);
		rd(`SSM_OFF_DATA, rv);
		chk("slave_data", rv, tx_word[7:0]);
		// slave transmit, one bit out per outside clock
		wr(`SSM_OFF_RXSC, PEN);
		talk <= 1'h0;
		wr(`SSM_OFF_TXSC, SYNC | TXON);
		u_far.clear();
		wr(`SSM_OFF_DATA, tx_word[15:8]);
		#7;
		u_far.run_clocks(8);
		repeat (20) @(posedge clk);
		chk("slave_tx_clocks", n_trail, 8);
		chk("slave_tx_bits", rx_word[31:24], tx_word[15:8]);
		wr(`SSM_OFF_RXSC, 8'h00);
		talk <= 1'h0;
		$display("test slave done");
	endtask
	// main sequence
	initial begin
		clk = 1'h0;
		flt = 1'h0;
		sys_rst = 1'h1;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		pol = 1'h0;
		talk = 1'h0;
		tx_word = 32'h00000000;
		lfsr_r = 32'h9E4E3824;
		n_mismatch = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'h0;
		test_regs();
		for (int i = 0; i < 4; i++)
			test_tx(i[0], i[1]);
		test_rx1(1'h0);
		test_rx1(1'h1);
		test_ovr();
		test_slave();
		wrap_up();
	end
	// watchdog against a hang
	initial begin
		#200000;
		n_mismatch++;
		wrap_up();
	end
endmodule
`default_nettype wire
